/* qw_pkg.sv */
// package: constants and carriers of the quad wrap-read / erase sequencer
// Functional notes
// [R1] quad mode 0Ch reads like fast read, wrapping
// [R2] quad mode 0Eh double-rate read, same wrapping
// [R3] wrap length, dummies from last C0h parameter; double-rate reads here keep 8 dummy clocks whatever the code
// [R4] wrap sections 8/16/32/64 bytes by two bits
// [R5] reset: 8-byte wrap, 10 dummies; double-rate 8
// [R6] dummy code 00/01/10/11 gives 10/4/6/8
// [R7] learn pattern only while enable bit set
// [R8] pattern starts after the mode-bit cycles
// [R9] pattern is constant 00110100
// [R10] single-rate: pattern bits beyond dummies are cut
// [R11] single-rate four dummies: no pattern
// [R12] double-rate: pattern in last four dummies
// [R13] host sets quad enable before 38h
// [R14] 38h enters quad mode only with quad enable
// [R15] FFh in quad mode returns to serial
// [R16] mode switch keeps latch and wrap length
// [R17] host sends write enable before erase
// [R18] erase starts at select rise, busy then clear
// [R19] 81h plus three bytes clears one page
// [R20] 20h clears sector chosen by A23..A12
// [R21] protected sector is not erased; 81h page clears here are not checked against protection
// [R22] erase only if select rises after 32 bits
// [R23] 52h clears the 32K block of address
// [R24] protected 32K block: no erase, latch cleared
// [R25] erase ignored while busy, status stays visible
package qw_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRAP_STR          = 8'h0c;
    localparam logic [7:0] CMD_WRAP_DTR          = 8'h0e;
    localparam logic [7:0] CMD_SET_PARAM         = 8'hc0;
    localparam logic [7:0] CMD_QUAD_ON           = 8'h38;
    localparam logic [7:0] CMD_QUAD_OFF          = 8'hff;
    localparam logic [7:0] CMD_WRITE_ENABLE      = 8'h06;
    localparam logic [7:0] CMD_PAGE_CLEAR        = 8'h81;
    localparam logic [7:0] CMD_SMALL_REGION_WIPE = 8'h20;
    localparam logic [7:0] CMD_HALF_BLOCK_CLEAR  = 8'h52;
    // ------------------------------------------------------------
    // read parameters and learning pattern
    // ------------------------------------------------------------
    localparam logic [7:0]  LEARN_PAT       = 8'h34;
    localparam logic [7:0]  PARAM_RST       = 8'h00; // 8-byte wrap, 10 dummies
    localparam int          WRAP_LSB        = 0;
    localparam int          DUMMY_LSB       = 4;
    localparam logic [5:0]  DUMMY_00        = 6'h0a;
    localparam logic [5:0]  DUMMY_01        = 6'h04;
    localparam logic [5:0]  DUMMY_10        = 6'h06;
    localparam logic [5:0]  DUMMY_11        = 6'h08;
    localparam logic [5:0]  DUMMY_NO_PAT    = 6'h04;
    localparam logic [5:0]  DTR_DUMMY_SLOTS = 6'h10; // 8 clocks, two edges each
    localparam logic [5:0]  DTR_PAT_START   = 6'h08; // last 4 clocks
    localparam logic [5:0]  MODE_SLOTS      = 6'h00; // wrap reads carry no mode bits
    localparam logic [5:0]  PAT_BITS        = 6'h08;
    localparam logic [23:0] WRAP_BASE       = 24'h000008;
    // ------------------------------------------------------------
    // frame bit counts
    // ------------------------------------------------------------
    localparam logic [5:0]  BITS_CMD        = 6'h08;
    localparam logic [5:0]  BITS_PARAM      = 6'h10;
    localparam logic [5:0]  BITS_ADDR       = 6'h20;
    localparam logic [5:0]  BITS_SAT        = 6'h3b;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ER_NONE = 2'b00, ER_PAGE = 2'b01, ER_SECT = 2'b10, ER_HALF = 2'b11
    } qw_erase_kind_t;
    typedef enum logic {ST_RX = 1'b0, ST_RD = 1'b1} qw_state_t;
    typedef struct packed {
        logic           go;
        qw_erase_kind_t kind;
        logic [23:0]    addr;
    } qw_erase_t;
    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
    } qw_sio_t;
endpackage

/* qw_wrap_flash.sv */
// design: read FIFO and quad wrap-read / erase sequencer of the flash
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// small flop FIFO with flush
// ----------------------------------------------------------------
module qw_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic         flush_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    if (D < 2 || (1 << AW) != D) begin : g_chk
        $error("fifo depth must be a power of two");
    end
    logic [W-1:0] mem_q [D];   // storage
    logic [W-1:0] mem_d [D];
    logic [AW-1:0] wp_q, wp_d; // write index
    logic [AW-1:0] rp_q, rp_d; // read index
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign in_ready_o  = cnt_q != (AW+1)'(D);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // next pointers and entries
    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (push) begin
            mem_d[wp_q] = in_data_i;
            wp_d        = wp_q + AW'(1);
        end
        if (pop) begin
            rp_d = rp_q + AW'(1);
        end
        // flush wins: a frame end drops stale bytes
        if (flush_i) begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = '0;
        end
    end

    // pointers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // one register per entry
    for (genvar i = 0; i < D; i++) begin : g_mem
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                mem_q[i] <= '0;
            end else begin
                mem_q[i] <= mem_d[i];
            end
        end
    end
endmodule

// ----------------------------------------------------------------
// sequencer top
// ----------------------------------------------------------------
module qw_wrap_flash #(
    parameter int ERASE_CYC  = 2000,
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    // flash pins
    input  wire logic          cs_n_i,
    input  wire logic          sclk_i,
    input  wire logic [3:0]    sio_i,
    output logic [3:0]         sio_o,
    output logic [3:0]         sio_oe_o,
    // configuration
    input  wire logic          quad_enable_bit_i,
    input  wire logic          learn_pattern_enable_i,
    input  wire logic [4:0]    protect_level_bits_i,
    // status
    output logic               write_enable_latch_o,
    output logic               op_in_progress_flag_o,
    output logic               quad_command_mode_o,
    // array read stream
    output logic [23:0]        arr_addr_o,
    input  wire logic          arr_valid_i,
    input  wire logic [7:0]    arr_data_i,
    output logic               arr_ready_o,
    // erase request to the array
    output qw_pkg::qw_erase_t  erase_o
);
    localparam int TW = $clog2(ERASE_CYC + 1);
    if (ERASE_CYC < 8) begin : g_chk
        $error("erase time too short");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic       cs_s1, cs_s2, cs_p;  // select, synced, previous
    logic       ck_s1, ck_s2, ck_p;  // serial clock
    logic [3:0] io_s1, io_s2;
    logic       rise, fall, cs_rise;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_p  <= 1'b1;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_p  <= 1'b0;
            io_s1 <= '0;
            io_s2 <= '0;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_p  <= cs_s2;
            ck_s1 <= sclk_i;
            ck_s2 <= ck_s1;
            ck_p  <= ck_s2;
            io_s1 <= sio_i;
            io_s2 <= io_s1;
        end
    end
    assign rise    = ck_s2 && !ck_p;
    assign fall    = !ck_s2 && ck_p;
    assign cs_rise = cs_s2 && !cs_p;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    qw_pkg::qw_state_t st_q, st_d;
    logic              qpi_q, qpi_d;    // quad command mode
    logic              wel_q, wel_d;    // write enable latch
    logic              wip_q, wip_d;    // erase busy
    logic [7:0]        par_q, par_d;    // read parameters
    logic [31:0]       sh_q, sh_d;      // incoming bits
    logic [5:0]        bcnt_q, bcnt_d;  // bits taken this frame
    logic [7:0]        cmd_q, cmd_d;
    logic              dtr_q, dtr_d;    // double-rate read
    logic [23:0]       fa_q, fa_d;      // fetch address
    logic [5:0]        oc_q, oc_d;      // output slot count
    logic              dph_q, dph_d;    // low nibble next
    logic [TW-1:0]     tmr_q, tmr_d;
    qw_pkg::qw_sio_t   sio_q, sio_d;
    qw_pkg::qw_erase_t er_q, er_d;

    // derived terms
    qw_pkg::qw_erase_kind_t er_kind;
    logic [5:0]  dummy_str, dslots, pst, pidx;
    logic [23:0] wmask, fa_next;
    logic        prot, pat_ok, push, pop, f_valid, push_rdy;
    logic [7:0]  f_data;

    // single-rate dummy count decode
    always_comb begin
        unique case (par_q[qw_pkg::DUMMY_LSB +: 2]) // R6 R5
            2'b00: dummy_str = qw_pkg::DUMMY_00;
            2'b01: dummy_str = qw_pkg::DUMMY_01;
            2'b10: dummy_str = qw_pkg::DUMMY_10;
            2'b11: dummy_str = qw_pkg::DUMMY_11;
        endcase
    end
    assign dslots = dtr_q ? qw_pkg::DTR_DUMMY_SLOTS : dummy_str; // R3
    // pattern follows mode bits; double-rate uses last 4 clocks
    assign pst    = dtr_q ? qw_pkg::DTR_PAT_START : qw_pkg::MODE_SLOTS; // R8 R12
    assign pidx   = oc_q - pst;
    assign pat_ok = learn_pattern_enable_i && oc_q >= pst // R7
                 && pidx < qw_pkg::PAT_BITS // R10
                 && (dtr_q || dummy_str != qw_pkg::DUMMY_NO_PAT); // R11
    // aligned wrap section inside the page
    assign wmask   = (qw_pkg::WRAP_BASE << par_q[qw_pkg::WRAP_LSB +: 2]) - 24'h000001; // R4
    assign fa_next = (fa_q & ~wmask) | ((fa_q + 24'h000001) & wmask); // R1 R2
    assign er_kind = (cmd_q == qw_pkg::CMD_PAGE_CLEAR)        ? qw_pkg::ER_PAGE :
                     (cmd_q == qw_pkg::CMD_SMALL_REGION_WIPE) ? qw_pkg::ER_SECT :
                     (cmd_q == qw_pkg::CMD_HALF_BLOCK_CLEAR)  ? qw_pkg::ER_HALF :
                                                                qw_pkg::ER_NONE;
    // top regions by protect level; page clears are not checked
    assign prot = (protect_level_bits_i != 5'h00)
               && (sh_q[22:18] > (5'h1f - protect_level_bits_i));
    // fetch only once the address is known; full FIFO stalls it
    assign arr_ready_o = push_rdy && st_q == qw_pkg::ST_RD && !cs_s2;
    assign push        = arr_valid_i && arr_ready_o;

    // ------------------------------------------------------------
    // next state of the sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d  = st_q;
        qpi_d = qpi_q;
        wel_d = wel_q;
        wip_d = wip_q;
        par_d = par_q;
        sh_d  = sh_q;
        bcnt_d = bcnt_q;
        cmd_d = cmd_q;
        dtr_d = dtr_q;
        fa_d  = fa_q;
        oc_d  = oc_q;
        dph_d = dph_q;
        tmr_d = tmr_q;
        sio_d = sio_q;
        er_d  = '0;
        pop   = 1'b0;
        // busy timer; completion drops latch too
        if (tmr_q != '0) begin
            tmr_d = tmr_q - TW'(1);
            if (tmr_q == TW'(1)) begin
                wip_d = 1'b0; // R18
                wel_d = 1'b0; // R18
            end
        end
        if (push) begin
            fa_d = fa_next; // R1 R2
        end
        if (cs_rise) begin
            // frame end: commands take effect here
            st_d   = qw_pkg::ST_RX;
            bcnt_d = '0;
            dtr_d  = 1'b0;
            sio_d  = '0;
            if (bcnt_q == qw_pkg::BITS_CMD && cmd_q == qw_pkg::CMD_WRITE_ENABLE && !wip_q) begin
                wel_d = 1'b1;
            end
            // mode switches leave latch and parameters alone
            if (bcnt_q == qw_pkg::BITS_CMD && cmd_q == qw_pkg::CMD_QUAD_ON && !qpi_q
                && quad_enable_bit_i) begin
                qpi_d = 1'b1; // R14 R16
            end
            if (bcnt_q == qw_pkg::BITS_CMD && cmd_q == qw_pkg::CMD_QUAD_OFF && qpi_q) begin
                qpi_d = 1'b0; // R15 R16
            end
            if (bcnt_q == qw_pkg::BITS_PARAM && cmd_q == qw_pkg::CMD_SET_PARAM && qpi_q) begin
                par_d = sh_q[7:0]; // R3
            end
            // exact length, latch set, not busy
            if (bcnt_q == qw_pkg::BITS_ADDR && er_kind != qw_pkg::ER_NONE // R22
                && wel_q && !wip_q) begin // R25
                if (!prot || er_kind == qw_pkg::ER_PAGE) begin // R21
                    wip_d      = 1'b1; // R18
                    tmr_d      = TW'(ERASE_CYC);
                    er_d.go    = 1'b1;
                    er_d.kind  = er_kind;
                    unique case (er_kind)
                        qw_pkg::ER_PAGE: er_d.addr = {sh_q[23:8], 8'h00};     // R19
                        qw_pkg::ER_SECT: er_d.addr = {sh_q[23:12], 12'h000};  // R20
                        default:         er_d.addr = {sh_q[23:15], 15'h0000}; // R23
                    endcase
                end else if (er_kind == qw_pkg::ER_HALF) begin
                    wel_d = 1'b0; // R24
                end
            end
        end else if (!cs_s2) begin
            unique case (st_q)
                qw_pkg::ST_RX: begin
                    // double-rate address also moves on falling edges
                    if (rise || (fall && dtr_q)) begin
                        sh_d   = qpi_q ? {sh_q[27:0], io_s2} : {sh_q[30:0], io_s2[0]};
                        bcnt_d = (bcnt_q > qw_pkg::BITS_SAT) ? 6'h3f
                               : bcnt_q + (qpi_q ? 6'h04 : 6'h01);
                        if (bcnt_d == qw_pkg::BITS_CMD) begin
                            cmd_d = sh_d[7:0];
                            dtr_d = qpi_q && sh_d[7:0] == qw_pkg::CMD_WRAP_DTR; // R2
                        end
                        if (bcnt_d == qw_pkg::BITS_ADDR && qpi_q
                            && (cmd_q == qw_pkg::CMD_WRAP_STR || cmd_q == qw_pkg::CMD_WRAP_DTR)) begin
                            st_d  = qw_pkg::ST_RD; // R1 R2
                            fa_d  = sh_d[23:0];
                            oc_d  = '0;
                            dph_d = 1'b0;
                        end
                    end
                end
                qw_pkg::ST_RD: begin
                    // drive on falling edge, both edges for double rate
                    if (fall || (dtr_q && rise)) begin
                        if (oc_q < dslots) begin
                            oc_d = oc_q + 6'h01;
                            if (pat_ok) begin
                                sio_d.dout = {4{qw_pkg::LEARN_PAT[3'h7 - pidx[2:0]]}}; // R9
                                sio_d.oe   = 4'hf;
                            end else begin
                                sio_d = '0;
                            end
                        end else begin
                            // high nibble first; underrun repeats the head
                            // count past the dummies so data never looks like a dummy slot
                            oc_d       = dslots + 6'h01;
                            sio_d.oe   = 4'hf;
                            sio_d.dout = dph_q ? f_data[3:0] : f_data[7:4];
                            dph_d      = !dph_q;
                            pop        = dph_q && f_valid;
                        end
                    end
                end
            endcase
        end
    end

    // registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q   <= qw_pkg::ST_RX;
            qpi_q  <= 1'b0;
            wel_q  <= 1'b0;
            wip_q  <= 1'b0;
            par_q  <= qw_pkg::PARAM_RST; // R5
            sh_q   <= '0;
            bcnt_q <= '0;
            cmd_q  <= '0;
            dtr_q  <= 1'b0;
            fa_q   <= '0;
            oc_q   <= '0;
            dph_q  <= 1'b0;
            tmr_q  <= '0;
            sio_q  <= '0;
            er_q   <= '0;
        end else begin
            st_q   <= st_d;
            qpi_q  <= qpi_d;
            wel_q  <= wel_d;
            wip_q  <= wip_d;
            par_q  <= par_d;
            sh_q   <= sh_d;
            bcnt_q <= bcnt_d;
            cmd_q  <= cmd_d;
            dtr_q  <= dtr_d;
            fa_q   <= fa_d;
            oc_q   <= oc_d;
            dph_q  <= dph_d;
            tmr_q  <= tmr_d;
            sio_q  <= sio_d;
            er_q   <= er_d;
        end
    end

    // read data buffer between array and pins
    qw_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .flush_i     (cs_rise),
        .in_valid_i  (arr_valid_i && st_q == qw_pkg::ST_RD && !cs_s2),
        .in_ready_o  (push_rdy),
        .in_data_i   (arr_data_i),
        .out_valid_o (f_valid),
        .out_ready_i (pop),
        .out_data_o  (f_data)
    );

    assign sio_o                 = sio_q.dout;
    assign sio_oe_o              = sio_q.oe;
    assign write_enable_latch_o  = wel_q;
    assign op_in_progress_flag_o = wip_q; // R25
    assign quad_command_mode_o   = qpi_q;
    assign arr_addr_o            = fa_q;
    assign erase_o               = er_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_wrap_in_section;
        push |=> ((fa_q ^ $past(fa_q)) & ~$past(wmask)) == 24'h000000;
    endproperty
    a_wrap_in_section: assert property (p_wrap_in_section) else $error("wrap left section"); // R1
    property p_quad_needs_qe;
        cs_rise && bcnt_q == qw_pkg::BITS_CMD && cmd_q == qw_pkg::CMD_QUAD_ON && !qpi_q
            |=> qpi_q == $past(quad_enable_bit_i);
    endproperty
    a_quad_needs_qe: assert property (p_quad_needs_qe) else $error("quad entry wrong"); // R14
    property p_quad_off;
        cs_rise && bcnt_q == qw_pkg::BITS_CMD && cmd_q == qw_pkg::CMD_QUAD_OFF |=> !qpi_q;
    endproperty
    a_quad_off: assert property (p_quad_off) else $error("quad exit failed"); // R15
    property p_mode_keeps;
        $changed(qpi_q) |-> $stable(par_q) && $stable(wel_q);
    endproperty
    a_mode_keeps: assert property (p_mode_keeps) else $error("mode switch lost state"); // R16
    property p_busy_span;
        er_q.go |-> wip_q [*8];
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy too short"); // R18
    property p_done_clears;
        $fell(wip_q) |-> !wel_q;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("latch kept after erase"); // R18
    property p_no_busy_start;
        er_q.go |-> $past(!wip_q && wel_q && bcnt_q == qw_pkg::BITS_ADDR);
    endproperty
    a_no_busy_start: assert property (p_no_busy_start) else $error("bad erase start"); // R25
    property p_prot_sect;
        cs_rise && er_kind == qw_pkg::ER_SECT && prot |=> !er_q.go;
    endproperty
    a_prot_sect: assert property (p_prot_sect) else $error("protected sector erased"); // R21
    property p_prot_half;
        cs_rise && er_kind == qw_pkg::ER_HALF && prot && wel_q && !wip_q
            && bcnt_q == qw_pkg::BITS_ADDR |=> !er_q.go && !wel_q;
    endproperty
    a_prot_half: assert property (p_prot_half) else $error("protected block mishandled"); // R24
    property p_no_pat4;
        st_q == qw_pkg::ST_RD && !dtr_q && dummy_str == qw_pkg::DUMMY_NO_PAT
            && oc_q != 6'h00 && oc_q <= dummy_str |-> sio_q.oe == 4'h0;
    endproperty
    a_no_pat4: assert property (p_no_pat4) else $error("pattern with four dummies"); // R11
    property p_pat_bits;
        st_q == qw_pkg::ST_RD && !dtr_q && sio_q.oe != 4'h0 && oc_q != 6'h00 && oc_q <= dummy_str
            |-> sio_q.dout == {4{qw_pkg::LEARN_PAT[3'(6'h08 - oc_q)]}};
    endproperty
    a_pat_bits: assert property (p_pat_bits) else $error("pattern bit wrong"); // R9
    c_erase: cover property (er_q.go);
    c_quad:  cover property ($rose(qpi_q));
    c_data:  cover property (pop);
    c_pat:   cover property (st_q == qw_pkg::ST_RD && sio_q.oe != 4'h0 && oc_q <= dslots);
endmodule

`default_nettype wire

/* qw_host.sv */
// host controller model that drives the flash pins
`timescale 1ns/100ps
`default_nettype none
module qw_host (
    // pins
    output logic            cs_n_o,
    output logic            sclk_o,
    output logic      [3:0] sio_o,
    input  wire logic [3:0] dev_i,
    input  wire logic       dev_oe_i
);
    logic       drv;    // host owns the data lines
    logic [3:0] hq;     // last host nibble
    logic [4:0] got[$]; // oe and data seen at each rise
    // released lines show the inverse, never a stale copy
    assign sio_o = dev_oe_i ? dev_i : (drv ? hq : ~hq);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        drv    = 1'b0;
        hq     = 4'h0;
    end
    // one clock of 125 ns; it stands still between frames
    task automatic unit(input logic [3:0] v, input logic d);
        drv <= d;
        if (d) hq <= v;
        cs_n_o <= 1'b0;
        #62.5 sclk_o <= 1'b1;
        got.push_back({dev_oe_i, dev_i});
        #62.5 sclk_o <= 1'b0;
    endtask
    // n units of v, msb first; quad sends nibbles
    task automatic send(input logic [31:0] v, input int n, input logic q);
        for (int i = 0; i < n; i++) begin
            unit(q ? v[31-4*i -: 4] : {4{v[31-i]}}, 1'b1);
        end
    endtask
    // dummy and data clocks with the lines released
    task automatic idle(input int n);
        repeat (n) unit(hq, 1'b0);
    endtask
    // select rises half a unit after the last clock falls
    task automatic done_frame;
        drv <= 1'b0;
        #62.5 cs_n_o <= 1'b1;
        #300;
    endtask
endmodule
`default_nettype wire

/* qw_wrap_flash_test.sv */
// self-checking bench of the wrap-read and erase sequencer
`timescale 1ns/100ps
`default_nettype none
module qw_wrap_flash_test;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [23:0] adr;
        logic [4:0]  prot;
        logic [1:0]  kind;
        logic [23:0] base;
        logic        write_enable_latch;
    } qw_row_t;
    // erase rows: command, address, protection, outcome
    qw_row_t rows[5] = '{
        '{8'h81, 24'h001234, 5'h00, 2'h1, 24'h001200, 1'b0},
        '{8'h20, 24'h012345, 5'h00, 2'h2, 24'h012000, 1'b0},
        '{8'h52, 24'h01abcd, 5'h00, 2'h3, 24'h018000, 1'b0},
        '{8'h52, 24'h7c0000, 5'h01, 2'h0, 24'h000000, 1'b0},
        '{8'h20, 24'h7c1000, 5'h01, 2'h0, 24'h000000, 1'b1}};
    logic              clk_i  = 1'b0;
    logic              nrst_i = 1'b0;
    logic              qe     = 1'b0;  // quad enable level
    logic              lpe    = 1'b0;  // learn pattern enable
    logic              av     = 1'b0;  // array byte valid
    logic [7:0]        ad     = 8'h00; // array byte
    logic [4:0]        prot   = 5'h00;
    logic              cs_n, sclk, write_enable_latch, busy, qm, ar;
    logic [3:0]        sio, dsio, doe, b;
    logic [23:0]       aa;
    qw_pkg::qw_erase_t er, last;
    int                errors = 0, checks = 0, gos = 0, cyc = 0, n0;
    always #5 clk_i = ~clk_i;
    qw_host HOST (.cs_n_o(cs_n), .sclk_o(sclk), .sio_o(sio), .dev_i(dsio), .dev_oe_i(doe[0]));
    qw_wrap_flash #(.ERASE_CYC(600), .FIFO_DEPTH(4)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .cs_n_i(cs_n), .sclk_i(sclk), .sio_i(sio), .sio_o(dsio), .sio_oe_o(doe),
        .quad_enable_bit_i(qe), .learn_pattern_enable_i(lpe), .protect_level_bits_i(prot),
        .write_enable_latch_o(write_enable_latch), .op_in_progress_flag_o(busy), .quad_command_mode_o(qm),
        .arr_addr_o(aa), .arr_valid_i(av), .arr_data_i(ad), .arr_ready_o(ar), .erase_o(er));
    // array stalls every other cycle; a byte equals its address
    always @(posedge clk_i) begin
        av  <= ~av && ar; // offer bytes only once the fetch address is loaded
        ad  <= aa[7:0];
        cyc <= cyc + 1;
        if (er.go === 1'b1) begin
            gos  <= gos + 1;
            last <= er;
        end
        if (cyc == 40000) begin
            errors++;
            stop_test;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("counts: %0d checks, %0d errors", checks, errors);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic frame(input logic [31:0] v, input int n, input logic q);
        HOST.send(v, n, q);
        HOST.done_frame;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        chk({write_enable_latch, busy, qm, er}, 0);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        foreach (rows[i]) begin
            prot <= rows[i].prot;
            frame(32'h06000000, 8, 1'b0);
            n0 = gos;
            frame({rows[i].cmd, rows[i].adr}, 32, 1'b0);
            chk(gos - n0, rows[i].kind != 2'h0);
            if (rows[i].kind != 2'h0) begin
                chk({last.kind, last.addr, busy}, {rows[i].kind, rows[i].base, 1'b1});
                frame({rows[i].cmd, rows[i].adr}, 32, 1'b0);
                chk(gos - n0, 1);
                repeat (1000) if (busy) @(posedge clk_i);
            end
            chk({busy, write_enable_latch}, {1'b0, rows[i].write_enable_latch});
            @(posedge clk_i);
            $display("erase row %0d done", i);
        end
        frame(32'h06000000, 8, 1'b0);
        n0 = gos;
        frame(32'h20012345, 31, 1'b0);
        chk({gos[3:0], write_enable_latch}, {n0[3:0], 1'b1});
        frame(32'h38000000, 8, 1'b0);
        chk(qm, 0);
        @(posedge clk_i);
        qe  <= 1'b1;
        lpe <= 1'b1;
        frame(32'h38000000, 8, 1'b0);
        chk({qm, write_enable_latch}, 2'b11);
        HOST.got.delete();
        HOST.send(32'h0c000006, 8, 1'b1);
        HOST.idle(18);
        HOST.done_frame;
        // pattern in the first eight dummies, then bytes 6, 7, 0, 1
        for (int k = 0; k < 18; k++) begin
            b = (k < 8) ? {4{qw_pkg::LEARN_PAT[7-k]}} : ((k % 2) ? 4'((6 + (k - 10) / 2) % 8) : 4'h0);
            if (k == 8 || k == 9) chk(HOST.got[8+k][4], 0);
            else chk(HOST.got[8+k], {1'b1, b});
        end
        frame(32'hc0110000, 4, 1'b1);
        HOST.got.delete();
        HOST.send(32'h0c00000e, 8, 1'b1);
        HOST.idle(10);
        HOST.done_frame;
        // four dummies carry no pattern; 16-byte wrap gives e, f, 0
        for (int k = 0; k < 10; k++) begin
            b = (k % 2) ? 4'(14 + (k - 5) / 2) : 4'h0;
            if (k < 4) chk(HOST.got[8+k][4], 0);
            else chk(HOST.got[8+k], {1'b1, b});
        end
        HOST.got.delete();
        HOST.send(32'h0e000000, 5, 1'b1);
        HOST.idle(9);
        HOST.done_frame;
        // host samples rising edges only: even slots, pattern bits 7, 5, 3, 1
        for (int k = 0; k < 9; k++) begin
            b = (k > 3 && k < 8) ? {4{qw_pkg::LEARN_PAT[15-2*k]}} : 4'h0;
            chk(HOST.got[5+k], {k > 3, b});
        end
        frame(32'hff000000, 2, 1'b1);
        chk({qm, write_enable_latch}, 2'b01);
        $display("quad mode and read done");
        stop_test;
    end
endmodule
`default_nettype wire
